// ===== rtl/gtm_pkg.sv
// Package for the generator tolerance monitor: constants, field widths and types
package gtm_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int MEAS_W = 16;
    localparam int PCT_W  = 12;   // Percent in tenths
    localparam int DLY_W  = 16;
    localparam logic [PCT_W-1:0] PCT_DIV = 12'h3E8; // 100.0 percent in tenths
    // ------------------------------------------------------------
    // Reset values of settings
    // ------------------------------------------------------------
    localparam logic [MEAS_W-1:0] SPD_NOM_RST  = 16'h05DC; // 1500 rpm
    localparam logic [PCT_W-1:0]  SPD_STOP_RST = 12'h064;  // 10.0 %
    localparam logic [PCT_W-1:0]  SPD_RUN_RST  = 12'h0C8;  // 20.0 %
    localparam logic [PCT_W-1:0]  SPD_LOW_RST  = 12'h384;  // 90.0 %
    localparam logic [PCT_W-1:0]  SPD_HIGH_RST = 12'h4B0;  // 120.0 %
    localparam logic [PCT_W-1:0]  HYST_RST     = 12'h019;  // 2.5 %
    localparam logic [MEAS_W-1:0] VLT_NOM_RST  = 16'h01E0; // 48.0 V in tenths
    localparam logic [PCT_W-1:0]  VLT_STOP_RST = 12'h0AF;  // 17.5 %
    localparam logic [PCT_W-1:0]  VLT_RUN_RST  = 12'h0C8;  // 20.0 %
    localparam logic [PCT_W-1:0]  VLT_LOW_RST  = 12'h2EE;  // 75.0 %
    localparam logic [PCT_W-1:0]  VLT_HIGH_RST = 12'h546;  // 135.0 %
    localparam logic [DLY_W-1:0]  DLY_RST      = 16'h0001;
    localparam logic [2:0]        LOG_EN_BIT   = 3'h2;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] A_SPD_NOM  = 5'h00;
    localparam logic [4:0] A_SPD_STOP = 5'h01;
    localparam logic [4:0] A_SPD_RUN  = 5'h02;
    localparam logic [4:0] A_SPD_LOW  = 5'h03;
    localparam logic [4:0] A_SPD_HIGH = 5'h04;
    localparam logic [4:0] A_HYST     = 5'h05;
    localparam logic [4:0] A_VLT_NOM  = 5'h06;
    localparam logic [4:0] A_VLT_STOP = 5'h07;
    localparam logic [4:0] A_VLT_RUN  = 5'h08;
    localparam logic [4:0] A_VLT_LOW  = 5'h09;
    localparam logic [4:0] A_VLT_HIGH = 5'h0A;
    localparam logic [4:0] A_DLY      = 5'h0B;
    localparam logic [4:0] A_CTRL     = 5'h0C;
    localparam logic [4:0] A_STATUS   = 5'h0D;
    localparam logic [4:0] A_IRQ_ST   = 5'h0E;
    localparam logic [4:0] A_IRQ_MSK  = 5'h0F;
    // ------------------------------------------------------------
    // Timing at 40 MHz
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 40000000;
    localparam int OUT_TIME_MS   = 2000;
    localparam int IN_TIME_MS    = 500;
    localparam int OUT_CYC       = (CLK_HZ / 1000) * OUT_TIME_MS;
    localparam int IN_CYC        = (CLK_HZ / 1000) * IN_TIME_MS;
    localparam int CNT_W         = 27;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GTM_ABSENT = 2'b00,
        GTM_LOW    = 2'b01,
        GTM_INTOL  = 2'b10,
        GTM_HIGH   = 2'b11
    } gtm_class_t;
    typedef enum logic [1:0] {
        GTM_G_OUT    = 2'b00,
        GTM_G_TO_IN  = 2'b01,
        GTM_G_IN     = 2'b10,
        GTM_G_TO_OUT = 2'b11
    } gtm_gen_t;
endpackage

// ===== rtl/gtm_cls_if.sv
// Interface carrying thresholds and class between top and classifier
`timescale 1ns/1ps
interface gtm_cls_if;
    import gtm_pkg::*;
    logic [MEAS_W-1:0] meas;
    logic [MEAS_W-1:0] nom;
    logic [PCT_W-1:0]  stopPct;
    logic [PCT_W-1:0]  runPct;
    logic [PCT_W-1:0]  lowPct;
    logic [PCT_W-1:0]  highPct;
    logic [PCT_W-1:0]  hystPct;
    logic              valid;
    gtm_class_t        cls;
    modport cfg (output meas, nom, stopPct, runPct, lowPct, highPct, hystPct, valid, input cls);
    modport eval (input meas, nom, stopPct, runPct, lowPct, highPct, hystPct, valid, output cls);
endinterface

// ===== rtl/gtm_classifier.sv
// Band classifier with entering-side hysteresis
`timescale 1ns/1ps
module gtm_classifier (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Thresholds and class
    gtm_cls_if.eval   c
);
    import gtm_pkg::*;

    gtm_class_t cls_r;
    gtm_class_t cls_nxt;

    function automatic logic [MEAS_W+PCT_W-1:0] scaled(input logic [MEAS_W-1:0] nom,
                                                       input logic [PCT_W:0] pct);
        logic [MEAS_W+PCT_W:0] p;
        p = (MEAS_W+PCT_W+1)'(nom) * (MEAS_W+PCT_W+1)'(pct);
        scaled = (MEAS_W+PCT_W)'(p / (MEAS_W+PCT_W+1)'(PCT_DIV));
    endfunction

    logic [MEAS_W+PCT_W-1:0] m;
    logic [MEAS_W+PCT_W-1:0] tStop;
    logic [MEAS_W+PCT_W-1:0] tRun;
    logic [MEAS_W+PCT_W-1:0] tLow;
    logic [MEAS_W+PCT_W-1:0] tLowH;
    logic [MEAS_W+PCT_W-1:0] tHigh;
    logic [MEAS_W+PCT_W-1:0] tHighH;

    always_comb begin
        m      = (MEAS_W+PCT_W)'(c.meas);
        tStop  = scaled(c.nom, {1'b0, c.stopPct});
        tRun   = scaled(c.nom, {1'b0, c.runPct});
        tLow   = scaled(c.nom, {1'b0, c.lowPct});
        tLowH  = scaled(c.nom, {1'b0, c.lowPct} + {1'b0, c.hystPct});
        tHigh  = scaled(c.nom, {1'b0, c.highPct});
        tHighH = (c.highPct > c.hystPct) ? scaled(c.nom, {1'b0, c.highPct - c.hystPct}) : '0;
        cls_nxt = cls_r;
        if (c.valid) begin
            if (m < tStop)
                cls_nxt = GTM_ABSENT;
            else if (m < tRun && cls_r == GTM_ABSENT)
                cls_nxt = GTM_ABSENT;
            else if (m < tLow)
                cls_nxt = GTM_LOW;
            else if (m > tHigh)
                cls_nxt = GTM_HIGH;
            else if (m >= tLowH && m <= tHighH)
                cls_nxt = GTM_INTOL;
            else if (cls_r == GTM_ABSENT)
                cls_nxt = GTM_LOW;
            else
                cls_nxt = cls_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n)
            cls_r <= GTM_ABSENT;
        else
            cls_r <= cls_nxt;
    end

    assign c.cls = cls_r;
endmodule // gtm_classifier

// ===== rtl/gtm_top.sv
// Generator tolerance monitor top: settings, generator state, events
`timescale 1ns/1ps
module gtm_top #(
    parameter int OUT_CYCLES = gtm_pkg::OUT_CYC,
    parameter int IN_CYCLES  = gtm_pkg::IN_CYC
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // Measurements from pins
    input  wire logic [gtm_pkg::MEAS_W-1:0]  speedMeas,
    input  wire logic                        speedValid,
    input  wire logic [gtm_pkg::MEAS_W-1:0]  voltMeas,
    // Register port
    input  wire logic [4:0]                  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [31:0]                 regRdata,
    // Results
    output logic                             loadPermit,
    output logic                             gen_in_tolerance_output,
    output logic                             state_gen_voltage_present,
    output logic                             state_gen_out_or_absent,
    output logic                             state_delay_to_in_tolerance,
    output logic                             state_gen_in_tolerance,
    output logic                             state_delay_to_out_or_absent,
    output logic                             speedLowProtTrip,
    output logic                             speedHighProtTrip,
    output logic                             voltLowProtTrip,
    output logic                             voltHighProtTrip,
    output logic                             event_gen_no_voltage,
    output logic                             event_gen_out_of_tolerance,
    output logic                             event_gen_in_tolerance,
    output logic                             irq
);
    import gtm_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [MEAS_W-1:0] spdS1_r, spdS2_r, vltS1_r, vltS2_r;
    logic              spdVS1_r, spdVS2_r;
    always_ff @(posedge clk) begin
        spdS1_r  <= speedMeas;
        spdS2_r  <= spdS1_r;
        spdVS1_r <= speedValid;
        spdVS2_r <= spdVS1_r;
        vltS1_r  <= voltMeas;
        vltS2_r  <= vltS1_r;
    end

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    logic [MEAS_W-1:0] spdNom_r, vltNom_r;
    logic [PCT_W-1:0]  spdStop_r, spdRun_r, spdLow_r, spdHigh_r, hyst_r;
    logic [PCT_W-1:0]  vltStop_r, vltRun_r, vltLow_r, vltHigh_r;
    logic [DLY_W-1:0]  dly_r;      // [15:0] voltage qualify cycles
    logic [7:0]        ctrl_r;     // Bits 1 to 4 protection enables; bit 2 is also the log enable
    logic [2:0]        irqSt_r, irqSt_nxt, irqMsk_r;
    logic [31:0]       rdata_nxt;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            spdNom_r  <= SPD_NOM_RST;
            spdStop_r <= SPD_STOP_RST;
            spdRun_r  <= SPD_RUN_RST;
            spdLow_r  <= SPD_LOW_RST;
            spdHigh_r <= SPD_HIGH_RST;
            hyst_r    <= HYST_RST;
            vltNom_r  <= VLT_NOM_RST;
            vltStop_r <= VLT_STOP_RST;
            vltRun_r  <= VLT_RUN_RST;
            vltLow_r  <= VLT_LOW_RST;
            vltHigh_r <= VLT_HIGH_RST;
            dly_r     <= DLY_RST;
            ctrl_r    <= 8'h00;
            irqMsk_r  <= 3'h0;
        end else if (regWr) begin
            case (regAddr)
                A_SPD_NOM:  spdNom_r  <= regWdata[MEAS_W-1:0];
                A_SPD_STOP: spdStop_r <= regWdata[PCT_W-1:0];
                A_SPD_RUN:  spdRun_r  <= regWdata[PCT_W-1:0];
                A_SPD_LOW:  spdLow_r  <= regWdata[PCT_W-1:0];
                A_SPD_HIGH: spdHigh_r <= regWdata[PCT_W-1:0];
                A_HYST:     hyst_r    <= regWdata[PCT_W-1:0];
                A_VLT_NOM:  vltNom_r  <= regWdata[MEAS_W-1:0];
                A_VLT_STOP: vltStop_r <= regWdata[PCT_W-1:0];
                A_VLT_RUN:  vltRun_r  <= regWdata[PCT_W-1:0];
                A_VLT_LOW:  vltLow_r  <= regWdata[PCT_W-1:0];
                A_VLT_HIGH: vltHigh_r <= regWdata[PCT_W-1:0];
                A_DLY:      dly_r     <= regWdata[DLY_W-1:0];
                A_CTRL:     ctrl_r    <= regWdata[7:0];
                A_IRQ_MSK:  irqMsk_r  <= regWdata[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Classifiers
    // ------------------------------------------------------------
    gtm_cls_if spdIf ();
    gtm_cls_if vltIf ();
    assign spdIf.meas    = spdS2_r;
    assign spdIf.nom     = spdNom_r;
    assign spdIf.stopPct = spdStop_r;
    assign spdIf.runPct  = spdRun_r;
    assign spdIf.lowPct  = spdLow_r;
    assign spdIf.highPct = spdHigh_r;
    assign spdIf.hystPct = hyst_r;
    assign spdIf.valid   = spdVS2_r;
    assign vltIf.meas    = vltS2_r;
    assign vltIf.nom     = vltNom_r;
    assign vltIf.stopPct = vltStop_r;
    assign vltIf.runPct  = vltRun_r;
    assign vltIf.lowPct  = vltLow_r;
    assign vltIf.highPct = vltHigh_r;
    assign vltIf.hystPct = hyst_r;
    assign vltIf.valid   = 1'b1;

    gtm_classifier uSpd (.clk(clk), .reset_n(reset_n), .c(spdIf.eval));
    gtm_classifier uVlt (.clk(clk), .reset_n(reset_n), .c(vltIf.eval));

    gtm_class_t spdCls, vltCls;
    assign spdCls = spdIf.cls;
    assign vltCls = vltIf.cls;

    // ------------------------------------------------------------
    // Protections and load permission
    // ------------------------------------------------------------
    logic bothIn, bothOut;
    always_comb begin
        bothIn  = (spdCls == GTM_INTOL) && (vltCls == GTM_INTOL);
        bothOut = (spdCls != GTM_INTOL) && (vltCls != GTM_INTOL);
    end

    always_comb begin
        speedLowProtTrip  = ctrl_r[1] && spdCls == GTM_LOW;
        speedHighProtTrip = ctrl_r[2] && spdCls == GTM_HIGH;
        voltLowProtTrip   = ctrl_r[3] && vltCls == GTM_LOW;
        voltHighProtTrip  = ctrl_r[4] && vltCls == GTM_HIGH;
    end

    // ------------------------------------------------------------
    // Generator state machine
    // ------------------------------------------------------------
    gtm_gen_t          gen_r, gen_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [DLY_W-1:0]  vq_r, vq_nxt;
    logic              vqOk_r, vqOk_nxt;

    always_comb begin
        gen_nxt = gen_r;
        cnt_nxt = cnt_r;
        case (gen_r)
            GTM_G_OUT: begin
                cnt_nxt = '0;
                if (bothIn) begin
                    gen_nxt = GTM_G_TO_IN;
                    cnt_nxt = CNT_W'(1);
                end
            end
            GTM_G_TO_IN: begin
                if (!bothIn) begin
                    gen_nxt = GTM_G_OUT;
                    cnt_nxt = '0;
                end else if (cnt_r >= CNT_W'(IN_CYCLES - 1)) begin
                    gen_nxt = GTM_G_IN;
                    cnt_nxt = '0;
                end else
                    cnt_nxt = cnt_r + CNT_W'(1);
            end
            GTM_G_IN: begin
                cnt_nxt = '0;
                if (bothOut) begin
                    gen_nxt = GTM_G_TO_OUT;
                    cnt_nxt = CNT_W'(1);
                end
            end
            GTM_G_TO_OUT: begin
                if (!bothOut) begin
                    gen_nxt = GTM_G_IN;
                    cnt_nxt = '0;
                end else if (cnt_r >= CNT_W'(OUT_CYCLES - 1)) begin
                    gen_nxt = GTM_G_OUT;
                    cnt_nxt = '0;
                end else
                    cnt_nxt = cnt_r + CNT_W'(1);
            end
            default: begin
                gen_nxt = GTM_G_OUT;
                cnt_nxt = '0;
            end
        endcase
        // Voltage-only qualification
        vq_nxt   = vq_r;
        vqOk_nxt = vqOk_r;
        if (vltCls != GTM_INTOL) begin
            vq_nxt   = '0;
            vqOk_nxt = 1'b0;
        end else if (vq_r >= dly_r) begin
            vqOk_nxt = 1'b1;
        end else
            vq_nxt = vq_r + DLY_W'(1);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gen_r  <= GTM_G_OUT;
            cnt_r  <= '0;
            vq_r   <= '0;
            vqOk_r <= 1'b0;
        end else begin
            gen_r  <= gen_nxt;
            cnt_r  <= cnt_nxt;
            vq_r   <= vq_nxt;
            vqOk_r <= vqOk_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs and events
    // ------------------------------------------------------------
    logic [1:0] stat_r, stat_nxt;   // 0 none, 1 out, 2 in
    logic [2:0] evt_nxt;
    logic [2:0] evt_r;
    logic       olp_r, olp_nxt;
    logic [5:0] st_r, st_nxt;

    always_comb begin
        olp_nxt  = bothIn && gen_r == GTM_G_IN;
        stat_nxt = (vltCls == GTM_ABSENT) ? 2'h0 : (gen_r == GTM_G_IN) ? 2'h2 : 2'h1;
        evt_nxt  = 3'h0;
        if (ctrl_r[LOG_EN_BIT] && stat_nxt != stat_r)
            evt_nxt[stat_nxt] = 1'b1;
        st_nxt = {vqOk_r,
                  gen_r == GTM_G_TO_OUT,
                  gen_r == GTM_G_IN,
                  gen_r == GTM_G_TO_IN,
                  gen_r == GTM_G_OUT,
                  vltCls != GTM_ABSENT};
        irqSt_nxt = irqSt_r;
        if (regWr && regAddr == A_IRQ_ST)
            irqSt_nxt = irqSt_r & ~regWdata[2:0];
        irqSt_nxt = irqSt_nxt | evt_nxt;
        rdata_nxt = 32'h0;
        if (regRd) begin
            case (regAddr)
                A_SPD_NOM:  rdata_nxt = 32'(spdNom_r);
                A_SPD_STOP: rdata_nxt = 32'(spdStop_r);
                A_SPD_RUN:  rdata_nxt = 32'(spdRun_r);
                A_SPD_LOW:  rdata_nxt = 32'(spdLow_r);
                A_SPD_HIGH: rdata_nxt = 32'(spdHigh_r);
                A_HYST:     rdata_nxt = 32'(hyst_r);
                A_VLT_NOM:  rdata_nxt = 32'(vltNom_r);
                A_VLT_STOP: rdata_nxt = 32'(vltStop_r);
                A_VLT_RUN:  rdata_nxt = 32'(vltRun_r);
                A_VLT_LOW:  rdata_nxt = 32'(vltLow_r);
                A_VLT_HIGH: rdata_nxt = 32'(vltHigh_r);
                A_DLY:      rdata_nxt = 32'(dly_r);
                A_CTRL:     rdata_nxt = 32'(ctrl_r);
                A_STATUS:   rdata_nxt = {20'h0, spdCls, vltCls, olp_r, st_r[5:0], 1'b0};
                A_IRQ_ST:   rdata_nxt = 32'(irqSt_r);
                A_IRQ_MSK:  rdata_nxt = 32'(irqMsk_r);
                default:    rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stat_r   <= 2'h0;
            evt_r    <= 3'h0;
            olp_r    <= 1'b0;
            st_r     <= 6'h02;
            irqSt_r  <= 3'h0;
            regRdata <= 32'h0;
        end else begin
            stat_r   <= stat_nxt;
            evt_r    <= evt_nxt;
            olp_r    <= olp_nxt;
            st_r     <= st_nxt;
            irqSt_r  <= irqSt_nxt;
            regRdata <= rdata_nxt;
        end
    end

    assign loadPermit                   = olp_r;
    assign gen_in_tolerance_output      = st_r[5];
    assign state_gen_voltage_present    = st_r[0];
    assign state_gen_out_or_absent      = st_r[1];
    assign state_delay_to_in_tolerance  = st_r[2];
    assign state_gen_in_tolerance       = st_r[3];
    assign state_delay_to_out_or_absent = st_r[4];
    assign event_gen_no_voltage         = evt_r[0];
    assign event_gen_out_of_tolerance   = evt_r[1];
    assign event_gen_in_tolerance       = evt_r[2];
    assign irq                          = |(irqSt_r & irqMsk_r);
endmodule // gtm_top

// ===== sim/gtm_meas_src.sv
// Speed and voltage measurement source model
`timescale 1ns/1ps
module gtm_meas_src (
    // Clock and bench settings
    input  wire logic        clk,
    input  wire logic [15:0] spdSet,
    input  wire logic [15:0] vltSet,
    input  wire logic        spdOn,
    // Measurements
    output logic      [15:0] speedMeas,
    output logic             speedValid,
    output logic      [15:0] voltMeas
);
    // Unacquired speed keeps moving
    always_ff @(posedge clk) begin
        speedMeas  <= spdOn ? spdSet : ~speedMeas;
        speedValid <= spdOn;
        voltMeas   <= vltSet;
    end
endmodule // gtm_meas_src

// ===== sim/gtm_top_assertions.sv
// Assertion checker for the tolerance monitor ports
`timescale 1ns/1ps
module gtm_top_assertions #(
    parameter int IN_CYCLES = 5
) (
    // Clock, reset, register port
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    // Results
    input wire logic        loadPermit,
    input wire logic        state_gen_out_or_absent,
    input wire logic        state_delay_to_in_tolerance,
    input wire logic        state_gen_in_tolerance,
    input wire logic        state_delay_to_out_or_absent,
    input wire logic        event_gen_no_voltage,
    input wire logic        event_gen_out_of_tolerance,
    input wire logic        event_gen_in_tolerance
);
    logic [7:0] toInCnt_r;
    logic [7:0] toInCnt_nxt;
    wire  [3:0] st = {state_gen_out_or_absent, state_delay_to_in_tolerance,
                      state_gen_in_tolerance, state_delay_to_out_or_absent};
    wire  [2:0] ev = {event_gen_in_tolerance, event_gen_out_of_tolerance, event_gen_no_voltage};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Cycles spent waiting for in tolerance
    always_comb toInCnt_nxt = state_delay_to_in_tolerance ? toInCnt_r + 8'h01 : 8'h00;
    always_ff @(posedge clk) begin
        if (!reset_n) toInCnt_r <= 8'h00;
        else toInCnt_r <= toInCnt_nxt;
    end
    AST_RST_OUT: assert property ($rose(reset_n) |-> state_gen_out_or_absent && !loadPermit)
        else $error("state after reset wrong");
    AST_ST_ONEHOT: assert property ($onehot(st))
        else $error("generator states not one-hot");
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    AST_EV_PULSE: assert property (|ev |=> !(|ev))
        else $error("event longer than one cycle");
    AST_EV_ONE: assert property ($onehot0(ev))
        else $error("two events at once");
    AST_IN_ENTRY: assert property ($rose(state_gen_in_tolerance) |->
        $past(state_delay_to_in_tolerance) || $past(state_delay_to_out_or_absent))
        else $error("stable in entered directly");
    AST_OUT_ENTRY: assert property ($rose(state_gen_out_or_absent) |->
        $past(state_delay_to_out_or_absent) || $past(state_delay_to_in_tolerance))
        else $error("stable out entered directly");
    AST_IN_QUAL: assert property ($rose(state_gen_in_tolerance) && $past(state_delay_to_in_tolerance)
        |-> toInCnt_r >= IN_CYCLES - 1)
        else $error("in tolerance qualified too early");
    AST_LOAD_IN: assert property (loadPermit |-> !state_gen_out_or_absent && !state_delay_to_in_tolerance)
        else $error("load permitted while not stable in");
    COV_IN: cover property ($rose(state_gen_in_tolerance));
    COV_OUT: cover property ($rose(state_gen_out_or_absent));
    COV_NOV: cover property (event_gen_no_voltage);
endmodule // gtm_top_assertions

// ===== sim/tb_top.sv
// Testbench for the generator tolerance monitor
`timescale 1ns/1ps
module tb_top;
    import gtm_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, spdOn = 1'b1, speedValid;
    logic [4:0] regAddr = 5'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [15:0] spdSet = 16'h0, vltSet = 16'h0, speedMeas, voltMeas;
    logic loadPermit, gen_in_tolerance_output, state_gen_voltage_present, state_gen_out_or_absent;
    logic state_delay_to_in_tolerance, state_gen_in_tolerance, state_delay_to_out_or_absent, irq;
    logic speedLowProtTrip, speedHighProtTrip, voltLowProtTrip, voltHighProtTrip;
    logic event_gen_no_voltage, event_gen_out_of_tolerance, event_gen_in_tolerance;
    int error_cnt = 0, checks = 0;
    always #12.5 clk = ~clk;
    gtm_meas_src u_src (.clk, .spdSet, .vltSet, .spdOn, .speedMeas, .speedValid, .voltMeas);
    gtm_top #(.OUT_CYCLES(20), .IN_CYCLES(5)) u_dut (.clk, .reset_n, .speedMeas, .speedValid,
        .voltMeas, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .loadPermit, .gen_in_tolerance_output,
        .state_gen_voltage_present, .state_gen_out_or_absent, .state_delay_to_in_tolerance,
        .state_gen_in_tolerance, .state_delay_to_out_or_absent, .speedLowProtTrip, .speedHighProtTrip,
        .voltLowProtTrip, .voltHighProtTrip, .event_gen_no_voltage, .event_gen_out_of_tolerance,
        .event_gen_in_tolerance, .irq);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdata & m, e);
    endtask
    task automatic setM(input logic [15:0] s, input logic [15:0] v, input logic on);
        @(posedge clk);
        spdSet <= s;
        vltSet <= v;
        spdOn <= on;
        repeat (6) @(posedge clk);
    endtask
    task automatic waitGen(input logic w);
        int i;
        for (i = 0; i < 80; i++) begin
            @(negedge clk);
            if ((w ? state_gen_in_tolerance : state_gen_out_or_absent) === 1'b1) break;
        end
        if (i == 80) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd(A_STATUS, 32'h004, 32'hFFF);
        rd(A_SPD_NOM, 32'h5DC, 32'hFFFF);
        rd(A_VLT_NOM, 32'h1E0, 32'hFFFF);
        rd(5'h10, 32'h0, 32'hFFFF_FFFF);
        $display("test reset done");
        wr(A_CTRL, 32'h04);
        wr(A_IRQ_MSK, 32'h7);
        setM(16'd1500, 16'd480, 1'b1);
        waitGen(1'b1);
        rd(A_STATUS, 32'hAD2, 32'hFFF);
        chk(loadPermit, 1'b1);
        rd(A_IRQ_ST, 32'h6, 32'h7);
        chk(irq, 1'b1);
        wr(A_IRQ_ST, 32'h7);
        rd(A_IRQ_ST, 32'h0, 32'h7);
        chk(irq, 1'b0);
        $display("test stable in done");
        setM(16'd1360, 16'd365, 1'b1);
        rd(A_STATUS, 32'hA00, 32'hF00);
        setM(16'd2000, 16'd365, 1'b0);
        rd(A_STATUS, 32'hA00, 32'hF00);
        setM(16'd1340, 16'd480, 1'b1);
        rd(A_STATUS, 32'h600, 32'hF00);
        chk(loadPermit, 1'b0);
        chk(gen_in_tolerance_output, 1'b1);
        chk(speedLowProtTrip, 1'b0);
        wr(A_CTRL, 32'h1E);
        chk(speedLowProtTrip, 1'b1);
        setM(16'd1360, 16'd480, 1'b1);
        rd(A_STATUS, 32'h600, 32'hF00);
        $display("test hysteresis done");
        wr(A_IRQ_MSK, 32'h0);
        setM(16'd1340, 16'd700, 1'b1);
        chk(voltHighProtTrip, 1'b1);
        waitGen(1'b0);
        rd(A_STATUS, 32'h700, 32'hF00);
        chk(gen_in_tolerance_output, 1'b0);
        rd(A_IRQ_ST, 32'h2, 32'h7);
        chk(irq, 1'b0);
        setM(16'd1900, 16'd700, 1'b1);
        chk(speedHighProtTrip, 1'b1);
        $display("test stable out done");
        setM(16'd50, 16'd50, 1'b1);
        rd(A_STATUS, 32'h000, 32'hF00);
        rd(A_IRQ_ST, 32'h3, 32'h7);
        wr(A_IRQ_MSK, 32'h1);
        chk(irq, 1'b1);
        setM(16'd50, 16'd90, 1'b1);
        rd(A_STATUS, 32'h000, 32'hF00);
        setM(16'd50, 16'd100, 1'b1);
        rd(A_STATUS, 32'h100, 32'hF00);
        chk(voltLowProtTrip, 1'b1);
        $display("test absent done");
        print_verdict();
    end
endmodule // tb_top
bind gtm_top gtm_top_assertions #(.IN_CYCLES(IN_CYCLES)) u_ast (.clk, .reset_n, .regRd, .regRdata,
    .loadPermit, .state_gen_out_or_absent, .state_delay_to_in_tolerance, .state_gen_in_tolerance,
    .state_delay_to_out_or_absent, .event_gen_no_voltage, .event_gen_out_of_tolerance, .event_gen_in_tolerance);
